// File: shared/front_panel_pkg.sv
// Summary of operation
// - Button presses step the port LED function
// - First shows ports 1-24, second 25-48
// - Third press moves to next function
// - Bank LED off lower, on upper bank
// - Optical port LEDs shown in every bank
// - Two reserved positions carry no port data
// - Power LED off, on, blinks on backup
// - CPU-run LED off booting, on running
// - Stack role: slave off, master on, redundant blinks
// - Link LED on up, off disabled, else blink
// - Collision LED copper only, optical always off
// - Transmit LED follows transmit activity
// - Receive LED follows receive activity
// - Duplex LED shows mode, optical always on
// - Flow LED on when any mode enabled
// - Gigabit autoneg link down keeps last mode
// - Aggregation LED on for group members
// - All LEDs on during reset
// - Self test runs before normal operation
// - All LEDs lit briefly at power-up
// - Stack connector LEDs show cable present
// - Both buttons held: module/stack reset, LEDs lit
package front_panel_pkg;

   // Clock rate and derived cycles per millisecond
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

   // Times in milliseconds, then in clock cycles
   localparam int unsigned LAMP_MS = 500;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned DEBOUNCE_MS = 20;
   localparam int unsigned MOD_RESET_MS = 2000;
   localparam int unsigned STACK_RESET_MS = 4000;
   localparam int unsigned LAMP_CYC = LAMP_MS * CYC_PER_MS;
   localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
   localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned MOD_RESET_CYC = MOD_RESET_MS * CYC_PER_MS;
   localparam int unsigned STACK_RESET_CYC = STACK_RESET_MS * CYC_PER_MS;

   // Port counts: 48 copper then two optical ports
   localparam int unsigned NUM_PORTS = 50;
   localparam int unsigned BANK_PORTS = 24;
   localparam int unsigned COPPER_PORTS = 48;

   // Register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;

   // Control fields and reset value
   localparam int unsigned CTRL_BOOT_BIT = 0;
   localparam int unsigned CTRL_ROUTER_BIT = 1;
   localparam int unsigned CTRL_ROLE_LSB = 2;
   localparam int unsigned CTRL_PASS_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // Status fields
   localparam int unsigned STAT_FN_LSB = 0;
   localparam int unsigned STAT_BANK_BIT = 3;
   localparam int unsigned STAT_PHASE_LSB = 4;
   localparam int unsigned STAT_CHORD_BIT = 6;
   localparam int unsigned STAT_MAIN_BIT = 7;
   localparam int unsigned STAT_BACKUP_BIT = 8;

   // Port display functions in button order
   typedef enum logic [2:0] {
      FN_LINK = 3'h0,
      FN_COLL = 3'h1,
      FN_TX = 3'h2,
      FN_RX = 3'h3,
      FN_DUPLEX = 3'h4,
      FN_FLOW = 3'h5,
      FN_AGGR = 3'h6
   } fn_t;
   localparam int unsigned NUM_FN = 7;

   // Unit phase, Gray coded along lamp, test, run
   typedef enum logic [1:0] {
      PH_LAMP = 2'h0,
      PH_TEST = 2'h1,
      PH_RUN = 2'h3
   } phase_t;

   // Stack role written by software
   typedef enum logic [1:0] {
      ROLE_SLAVE = 2'h0,
      ROLE_MASTER = 2'h1,
      ROLE_STANDALONE = 2'h2,
      ROLE_MASTER_REDUNDANT = 2'h3
   } role_t;

   // Per-port state from the switching logic
   typedef struct packed {
      logic [NUM_PORTS-1:0] linkUp;
      logic [NUM_PORTS-1:0] enabled;
      logic [NUM_PORTS-1:0] collision;
      logic [NUM_PORTS-1:0] fullDuplex;
      logic [NUM_PORTS-1:0] txAct;
      logic [NUM_PORTS-1:0] rxAct;
      logic [NUM_PORTS-1:0] flowEn;
      logic [NUM_PORTS-1:0] autoNeg;
      logic [NUM_PORTS-1:0] lagMember;
   } portStatus_t;

   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } regReq_t;

   // Every front-panel LED, one for lit
   typedef struct packed {
      logic [BANK_PORTS-1:0] portLed;
      logic [1:0] opticalLed;
      logic [1:0] reservedLed;
      logic [NUM_FN-1:0] functionLed;
      logic bankLed;
      logic power_indicator;
      logic cpu_run_indicator;
      logic stack_role_indicator;
      logic routing_mode_indicator;
      logic stackUpperLed;
      logic stackLowerLed;
   } frontLeds_t;

endpackage : front_panel_pkg

// File: design/button_conditioner.sv
`timescale 1ns/1ps
module button_conditioner #(
   parameter int unsigned DEBOUNCE_CYC = 2_000_000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic button_n,
   output logic held,
   output logic pressed
);

   logic syncA_ff; // First synchroniser stage
   logic syncB_ff; // Second stage, the only one logic reads
   logic [31:0] stableCnt_ff; // Cycles the sample has disagreed
   logic held_ff; // Debounced level
   logic pressed_ff; // One-cycle press pulse

   // Two flops before anything looks at the pin
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         syncA_ff <= 1'b0;
         syncB_ff <= 1'b0;
      end else begin
         syncA_ff <= ~button_n;
         syncB_ff <= syncA_ff;
      end
   end

   // Accept a new level only after it stays put; contact bounce
   // would otherwise count as several presses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stableCnt_ff <= 32'h0;
         held_ff <= 1'b0;
         pressed_ff <= 1'b0;
      end else begin
         pressed_ff <= 1'b0;
         if (syncB_ff == held_ff) begin
            stableCnt_ff <= 32'h0;
         end else if (stableCnt_ff >= DEBOUNCE_CYC - 1) begin
            stableCnt_ff <= 32'h0;
            held_ff <= syncB_ff;
            pressed_ff <= syncB_ff;
         end else begin
            stableCnt_ff <= stableCnt_ff + 32'h1;
         end
      end
   end

   assign held = held_ff;
   assign pressed = pressed_ff;

endmodule : button_conditioner

// File: design/front_panel_led_selector.sv
`timescale 1ns/1ps
module front_panel_led_selector #(
   parameter int unsigned LAMP_CYC = front_panel_pkg::LAMP_CYC,
   parameter int unsigned BLINK_HALF_CYC = front_panel_pkg::BLINK_HALF_CYC,
   parameter int unsigned DEBOUNCE_CYC = front_panel_pkg::DEBOUNCE_CYC,
   parameter int unsigned MOD_RESET_CYC = front_panel_pkg::MOD_RESET_CYC,
   parameter int unsigned STACK_RESET_CYC = front_panel_pkg::STACK_RESET_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire front_panel_pkg::regReq_t regReq,
   output logic [31:0] regRdata,
   input wire front_panel_pkg::portStatus_t portStatus,
   input wire logic leftButton_n,
   input wire logic rightButton_n,
   input wire logic mainPowerOk,
   input wire logic backupPowerOk,
   input wire logic upperCableSense,
   input wire logic lowerCableSense,
   output front_panel_pkg::frontLeds_t leds,
   output logic moduleResetReq,
   output logic stackResetReq
);
   import front_panel_pkg::*;

   // Debounced buttons
   logic leftHeld; // Left button level
   logic leftPress; // Left button press pulse
   logic rightHeld; // Right button level
   logic rightPress; // Right button press pulse

   // Synchronised status pins, two flops each
   logic [3:0] pinSyncA_ff; // First stage only feeds second
   logic [3:0] pinSyncB_ff; // Usable levels
   logic mainOk; // Main supply present
   logic backupOk; // Backup supply present
   logic upperCable; // Cable in upper stacking connector
   logic lowerCable; // Cable in lower stacking connector

   // Control and display state
   logic [4:0] ctrl_ff; // Software control bits
   phase_t phase_ff; // Lamp, test or run
   logic [31:0] lampCnt_ff; // Lamp test timer
   fn_t fn_ff; // Selected port function
   logic bank_ff; // Upper port bank shown
   logic [31:0] blinkCnt_ff; // Blink half-period timer
   logic blink_ff; // Blink phase
   logic [31:0] chordCnt_ff; // Time both buttons held
   logic chord; // Both buttons held now
   logic [1:0] fcHeld_ff; // Last negotiated flow mode, optical
   logic [31:0] regRdata_ff; // Read data register
   frontLeds_t leds_ff; // LED output flops
   frontLeds_t nxt_leds; // Next LED value
   logic moduleReset_ff; // Module reset request
   logic stackReset_ff; // Stack reset request

   // Per-port value of each function
   logic [NUM_PORTS-1:0] fnBits [NUM_FN];
   role_t role; // Stack role from control
   fn_t nxt_fn; // Next function
   logic nxt_bank; // Next bank

   button_conditioner #(
      .DEBOUNCE_CYC(DEBOUNCE_CYC)
   ) u_left (
      .clk(clk),
      .sys_rst(sys_rst),
      .button_n(leftButton_n),
      .held(leftHeld),
      .pressed(leftPress)
   );

   button_conditioner #(
      .DEBOUNCE_CYC(DEBOUNCE_CYC)
   ) u_right (
      .clk(clk),
      .sys_rst(sys_rst),
      .button_n(rightButton_n),
      .held(rightHeld),
      .pressed(rightPress)
   );

   // Pin synchronisers; supplies and cable senses are asynchronous
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pinSyncA_ff <= 4'h0;
         pinSyncB_ff <= 4'h0;
      end else begin
         pinSyncA_ff <= {lowerCableSense, upperCableSense,
                         backupPowerOk, mainPowerOk};
         pinSyncB_ff <= pinSyncA_ff;
      end
   end

   assign mainOk = pinSyncB_ff[0];
   assign backupOk = pinSyncB_ff[1];
   assign upperCable = pinSyncB_ff[2];
   assign lowerCable = pinSyncB_ff[3];
   assign chord = leftHeld & rightHeld;
   assign role = role_t'(ctrl_ff[CTRL_ROLE_LSB +: 2]);

   // Register writes; only the control word is writable
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= CTRL_RESET;
      end else if (regReq.wr && regReq.addr == CTRL_OFS) begin
         ctrl_ff <= regReq.wdata[4:0];
      end
   end

   // Register reads, answered in the next cycle only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdata_ff <= 32'h0;
      end else if (regReq.rd) begin
         case (regReq.addr)
            CTRL_OFS: begin
               regRdata_ff <= {27'h0, ctrl_ff};
            end
            STATUS_OFS: begin
               regRdata_ff <= 32'h0;
               regRdata_ff[STAT_FN_LSB +: 3] <= fn_ff;
               regRdata_ff[STAT_BANK_BIT] <= bank_ff;
               regRdata_ff[STAT_PHASE_LSB +: 2] <= phase_ff;
               regRdata_ff[STAT_CHORD_BIT] <= chord;
               regRdata_ff[STAT_MAIN_BIT] <= mainOk;
               regRdata_ff[STAT_BACKUP_BIT] <= backupOk;
            end
            // Unmapped addresses read as zero
            default: begin
               regRdata_ff <= 32'h0;
            end
         endcase
      end else begin
         regRdata_ff <= 32'h0;
      end
   end

   // Unit phase: lamp test, then self test, then normal indication
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_ff <= PH_LAMP;
         lampCnt_ff <= 32'h0;
      end else begin
         case (phase_ff)
            PH_LAMP: begin
               if (lampCnt_ff >= LAMP_CYC - 1) begin
                  phase_ff <= PH_TEST;
               end else begin
                  lampCnt_ff <= lampCnt_ff + 32'h1;
               end
            end
            PH_TEST: begin
               if (ctrl_ff[CTRL_PASS_BIT]) begin
                  phase_ff <= PH_RUN;
               end
            end
            PH_RUN: begin
               phase_ff <= PH_RUN;
            end
            default: begin
               phase_ff <= PH_LAMP;
            end
         endcase
      end
   end

   // Free-running blink phase shared by all blinking LEDs
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blinkCnt_ff <= 32'h0;
         blink_ff <= 1'b0;
      end else if (blinkCnt_ff >= BLINK_HALF_CYC - 1) begin
         blinkCnt_ff <= 32'h0;
         blink_ff <= ~blink_ff;
      end else begin
         blinkCnt_ff <= blinkCnt_ff + 32'h1;
      end
   end

   // Selection step: right walks forward, left walks backward,
   // each function taking lower bank then upper bank
   always_comb begin
      nxt_fn = fn_ff;
      nxt_bank = bank_ff;
      if (rightPress && !leftHeld) begin
         if (!bank_ff) begin
            nxt_bank = 1'b1;
         end else begin
            nxt_bank = 1'b0;
            if (fn_ff == FN_AGGR) begin
               nxt_fn = FN_LINK;
            end else begin
               nxt_fn = fn_t'(fn_ff + 3'h1);
            end
         end
      end else if (leftPress && !rightHeld) begin
         if (bank_ff) begin
            nxt_bank = 1'b0;
         end else begin
            nxt_bank = 1'b1;
            if (fn_ff == FN_LINK) begin
               nxt_fn = FN_AGGR;
            end else begin
               nxt_fn = fn_t'(fn_ff - 3'h1);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fn_ff <= FN_LINK;
         bank_ff <= 1'b0;
      end else if (phase_ff == PH_RUN) begin
         fn_ff <= nxt_fn;
         bank_ff <= nxt_bank;
      end
   end

   // both-button reset timing; requests stand while held
   // so a press shorter than the limit raises nothing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chordCnt_ff <= 32'h0;
         moduleReset_ff <= 1'b0;
         stackReset_ff <= 1'b0;
      end else if (!chord) begin
         chordCnt_ff <= 32'h0;
         moduleReset_ff <= 1'b0;
         stackReset_ff <= 1'b0;
      end else begin
         if (chordCnt_ff < STACK_RESET_CYC) begin
            chordCnt_ff <= chordCnt_ff + 32'h1;
         end
         if (chordCnt_ff >= MOD_RESET_CYC - 1) begin
            moduleReset_ff <= 1'b1;
         end
         if (chordCnt_ff >= STACK_RESET_CYC - 1) begin
            stackReset_ff <= 1'b1;
         end
      end
   end

   // keep last negotiated flow mode while link is up
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fcHeld_ff <= 2'h0;
      end else begin
         for (int g = 0; g < 2; g++) begin
            if (portStatus.linkUp[COPPER_PORTS + g]) begin
               fcHeld_ff[g] <= portStatus.flowEn[COPPER_PORTS + g];
            end
         end
      end
   end

   // Each port's value for every function
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      localparam bit OPTICAL = (p >= COPPER_PORTS);
      always_comb begin
         if (portStatus.linkUp[p]) begin
            fnBits[FN_LINK][p] = 1'b1;
         end else begin
            fnBits[FN_LINK][p] = portStatus.enabled[p] & blink_ff;
         end
         fnBits[FN_COLL][p] = !OPTICAL && portStatus.collision[p]
                              && !portStatus.fullDuplex[p];
         fnBits[FN_TX][p] = portStatus.txAct[p];
         fnBits[FN_RX][p] = portStatus.rxAct[p];
         fnBits[FN_DUPLEX][p] = OPTICAL || portStatus.fullDuplex[p];
         fnBits[FN_FLOW][p] = portStatus.flowEn[p];
         if (OPTICAL && portStatus.autoNeg[p] && !portStatus.linkUp[p]) begin
            fnBits[FN_FLOW][p] = fcHeld_ff[p % 2];
         end
         fnBits[FN_AGGR][p] = portStatus.lagMember[p];
      end
   end

   // Next LED picture
   always_comb begin
      nxt_leds = '0;
      nxt_leds.opticalLed = fnBits[fn_ff][NUM_PORTS-1 -: 2];
      if (bank_ff) begin
         nxt_leds.portLed = fnBits[fn_ff][BANK_PORTS +: BANK_PORTS];
      end else begin
         nxt_leds.portLed = fnBits[fn_ff][0 +: BANK_PORTS];
      end
      nxt_leds.reservedLed = 2'h0;
      nxt_leds.functionLed[fn_ff] = 1'b1;
      nxt_leds.bankLed = bank_ff;
      if (mainOk) begin
         nxt_leds.power_indicator = 1'b1;
      end else begin
         nxt_leds.power_indicator = backupOk & blink_ff;
      end
      nxt_leds.cpu_run_indicator = ctrl_ff[CTRL_BOOT_BIT];
      case (role)
         ROLE_SLAVE: begin
            nxt_leds.stack_role_indicator = 1'b0;
         end
         ROLE_MASTER_REDUNDANT: begin
            nxt_leds.stack_role_indicator = blink_ff;
         end
         default: begin
            nxt_leds.stack_role_indicator = 1'b1;
         end
      endcase
      nxt_leds.routing_mode_indicator = ctrl_ff[CTRL_ROUTER_BIT];
      nxt_leds.stackUpperLed = upperCable;
      nxt_leds.stackLowerLed = lowerCable;
      // Before normal operation the panel shows no port picture;
      // the lamp test lights everything, self test clears port, function, bank and CPU-run LEDs
      if (phase_ff == PH_LAMP) begin
         nxt_leds = '1;
      end else if (phase_ff == PH_TEST) begin
         nxt_leds.portLed = '0;
         nxt_leds.opticalLed = 2'h0;
         nxt_leds.functionLed = '0;
         nxt_leds.bankLed = 1'b0;
         nxt_leds.cpu_run_indicator = 1'b0;
      end
      if (chord) begin
         nxt_leds = '1;
      end
   end

   // LED output flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         leds_ff <= '1;
      end else begin
         leds_ff <= nxt_leds;
      end
   end

   assign leds = leds_ff;
   assign regRdata = regRdata_ff;
   assign moduleResetReq = moduleReset_ff;
   assign stackResetReq = stackReset_ff;

endmodule : front_panel_led_selector

// File: sim/front_panel_led_selector_asserts.sv
`timescale 1ns/1ps
module front_panel_led_selector_asserts (
   input wire logic clk,
   input wire logic sys_rst,
   input wire front_panel_pkg::portStatus_t portStatus,
   input wire front_panel_pkg::frontLeds_t leds,
   input wire logic moduleResetReq,
   input wire logic stackResetReq
);
   import front_panel_pkg::*;
   // One clock domain, reset masks every check
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Lamp picture holds for the first cycles after release
   property p_lamp;
      $fell(sys_rst) |-> (&leds) [*8];
   endproperty
   a_lamp: assert property (p_lamp)
      else $error("LEDs not all lit after reset");
   // Reserved positions dark outside the all-lit states
   property p_resv;
      leds.functionLed != 7'h7f |-> leds.reservedLed == 2'b00;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved LEDs lit");
   // Collision never shows on the optical pair
   property p_coll;
      leds.functionLed == 7'h02 |-> leds.opticalLed == 2'b00;
   endproperty
   a_coll: assert property (p_coll)
      else $error("optical collision lit");
   // Optical ports are full duplex only
   property p_dup;
      leds.functionLed == 7'h10 |-> leds.opticalLed == 2'b11;
   endproperty
   a_dup: assert property (p_dup)
      else $error("optical duplex dark");
   // Transmit shown for the selected bank, one cycle behind
   property p_tx;
      leds.functionLed == 7'h04 |-> leds.portLed == (leds.bankLed ?
         $past(portStatus.txAct[47:24]) : $past(portStatus.txAct[23:0]));
   endproperty
   a_tx: assert property (p_tx)
      else $error("transmit LEDs wrong");
   // Receive on the optical pair in every bank
   property p_rx;
      leds.functionLed == 7'h08 |->
         leds.opticalLed == $past(portStatus.rxAct[49:48]);
   endproperty
   a_rx: assert property (p_rx)
      else $error("optical receive LEDs wrong");
   // Group membership on the optical pair
   property p_aggr;
      leds.functionLed == 7'h40 |->
         leds.opticalLed == $past(portStatus.lagMember[49:48]);
   endproperty
   a_aggr: assert property (p_aggr)
      else $error("optical aggregation LEDs wrong");
   // Exactly one function lit while running
   property p_onehot;
      leds.cpu_run_indicator && leds.functionLed != 7'h7f
         |-> $onehot(leds.functionLed);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("function LEDs not one-hot");
   // Stack reset implies module reset, chord keeps all lit
   property p_chord;
      stackResetReq |-> moduleResetReq && (&leds);
   endproperty
   a_chord: assert property (p_chord)
      else $error("stack reset without module reset or lit LEDs");
endmodule : front_panel_led_selector_asserts

bind front_panel_led_selector front_panel_led_selector_asserts
   i_front_panel_led_selector_asserts (
   .clk(clk), .sys_rst(sys_rst), .portStatus(portStatus), .leds(leds),
   .moduleResetReq(moduleResetReq), .stackResetReq(stackResetReq)
);

// File: sim/front_panel_operator.sv
`timescale 1ns/1ps
module front_panel_operator #(
   parameter int unsigned HOLD = 10
) (
   input wire logic clk,
   output logic leftButton_n,
   output logic rightButton_n
);
   // Released buttons sit at the pulled-up level
   initial begin
      leftButton_n = 1'b1;
      rightButton_n = 1'b1;
   end
   task automatic hold(input logic l, input logic r);
      leftButton_n <= !l;
      rightButton_n <= !r;
   endtask : hold
   // Low and high both outlast the debounce window
   task automatic press(input logic right);
      hold(!right, right);
      repeat (HOLD) @(posedge clk);
      hold(1'b0, 1'b0);
      repeat (HOLD) @(posedge clk);
   endtask : press
endmodule : front_panel_operator

// File: sim/tb_front_panel_led_selector.sv
`timescale 1ns/1ps
module tb_front_panel_led_selector;
   import front_panel_pkg::*;
   localparam int unsigned LAMP = 20;
   logic clk, sys_rst, leftButton_n, rightButton_n, probe, togClr, prevBit;
   logic mainOk, backupOk, upSense, lowSense, modReq, stkReq;
   regReq_t regReq;
   logic [31:0] regRdata;
   portStatus_t ps;
   frontLeds_t leds;
   logic [1:0] sel;
   logic [5:0] watch;
   logic [7:0] togCnt;
   logic [63:0] notes[$];
   int fail_count, check_count, f;
   logic b;
   logic [49:0] lm;
   // Observed words: port side, unit side, and both for blink watching
   wire [31:0] ledA = {3'b0, leds.bankLed, leds.reservedLed,
      leds.opticalLed, leds.portLed};
   wire [31:0] ledB = {17'h0, leds.functionLed, leds.power_indicator,
      leds.cpu_run_indicator, leds.stack_role_indicator,
      leds.routing_mode_indicator, leds.stackUpperLed, leds.stackLowerLed,
      modReq, stkReq};
   wire [63:0] both = {ledB, ledA};
   wire [31:0] obs = sel == 2'd0 ? regRdata : sel == 2'd1 ? ledA :
      sel == 2'd2 ? ledB : {24'h0, togCnt};

   front_panel_led_selector #(.LAMP_CYC(LAMP), .BLINK_HALF_CYC(4),
      .DEBOUNCE_CYC(3), .MOD_RESET_CYC(50), .STACK_RESET_CYC(100)
   ) i_front_panel_led_selector (.clk(clk), .sys_rst(sys_rst),
      .regReq(regReq), .regRdata(regRdata), .portStatus(ps),
      .leftButton_n(leftButton_n), .rightButton_n(rightButton_n),
      .mainPowerOk(mainOk), .backupPowerOk(backupOk),
      .upperCableSense(upSense), .lowerCableSense(lowSense),
      .leds(leds), .moduleResetReq(modReq), .stackResetReq(stkReq));
   front_panel_operator i_front_panel_operator (.clk(clk),
      .leftButton_n(leftButton_n), .rightButton_n(rightButton_n));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Toggle counter on the watched bit, then oldest note compare
   always @(posedge clk) begin : mon
      logic [63:0] n;
      prevBit <= both[watch];
      if (togClr) togCnt <= 8'h0;
      else if (both[watch] !== prevBit) togCnt <= togCnt + 8'h1;
      if (probe) begin
         n = notes.pop_front();
         check_count++;
         if ((obs & n[31:0]) !== (n[63:32] & n[31:0])) begin
            fail_count++;
            $display("MISMATCH %0t sel %0d got %h exp %h", $time, sel,
               obs, n[63:32]);
         end
      end
   end
   // Note an expectation and flag the result for the monitor
   task automatic note(input logic [1:0] s, input logic [31:0] e,
      input logic [31:0] m);
      notes.push_back({e, m});
      sel <= s;
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
      @(posedge clk);
   endtask : note
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      regReq.wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      regReq.rd <= 1'b0;
      note(2'd0, e, m);
   endtask : rd
   // Twelve cycles hold exactly three flips at a half period of four
   task automatic blink(input logic [5:0] i, input logic [7:0] e);
      watch <= i;
      togClr <= 1'b1;
      @(posedge clk);
      togClr <= 1'b0;
      repeat (12) @(posedge clk);
      note(2'd3, {24'h0, e}, 32'hff);
   endtask : blink
   task automatic shuffle();
      logic [479:0] v;
      portStatus_t p;
      for (int i = 0; i < 15; i++) v[i*32 +: 32] = $urandom();
      p = v[$bits(p)-1:0];
      p.linkUp[49:48] = 2'b11;
      ps <= p;
   endtask : shuffle
   // Expected optical pair and bank slice for a function
   function automatic logic [25:0] pexp(input int fn, input logic bk);
      logic [49:0] v;
      case (fn)
         0: v = ps.linkUp;
         1: v = ps.collision & ~ps.fullDuplex & {2'b00, {48{1'b1}}};
         2: v = ps.txAct;
         3: v = ps.rxAct;
         4: v = ps.fullDuplex | {2'b11, 48'h0};
         5: v = ps.flowEn;
         default: v = ps.lagMember;
      endcase
      return {v[49:48], bk ? v[47:24] : v[23:0]};
   endfunction : pexp
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // A hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      sys_rst = 1'b1; regReq = '0; ps = '0; mainOk = 1'b1; backupOk = 1'b0;
      upSense = 1'b0; lowSense = 1'b0; probe = 1'b0; togClr = 1'b0;
      sel = 2'd0; watch = 6'd0; fail_count = 0; check_count = 0;
      void'($urandom(79));
      repeat (3) @(posedge clk);
      note(2'd1, 32'h1fffffff, '1);
      note(2'd2, 32'h7ffc, '1);
      sys_rst <= 1'b0;
      @(posedge clk);
      note(2'd1, 32'h1fffffff, '1);
      repeat (LAMP) @(posedge clk);
      rd(8'h04, 32'h10, 32'h30);
      note(2'd1, 32'h0, '1);
      wr(8'h00, 32'h10);
      rd(8'h04, 32'h30, 32'h3f);
      note(2'd2, 32'h100, 32'h140);
      wr(8'h00, 32'h13);
      note(2'd2, 32'h50, 32'h50);
      // Status is read only, unmapped space reads zero
      wr(8'h04, 32'hffffffff);
      rd(8'h00, 32'h13, '1);
      rd(8'h08, 32'h0, '1);
      for (int r = 0; r < 4; r++) begin
         wr(8'h00, 32'h13 | 32'(r << 2));
         if (r == 3) blink(6'd37, 8'd3);
         else note(2'd2, r != 0 ? 32'h20 : 32'h0, 32'h20);
      end
      mainOk <= 1'b0;
      backupOk <= 1'b1;
      repeat (6) @(posedge clk);
      blink(6'd39, 8'd3);
      backupOk <= 1'b0;
      repeat (6) @(posedge clk);
      note(2'd2, 32'h0, 32'h80);
      mainOk <= 1'b1;
      for (int c = 1; c < 4; c++) begin
         {upSense, lowSense} <= 2'(c);
         repeat (6) @(posedge clk);
         note(2'd2, 32'h80 | 32'(c << 2), 32'h8c);
      end
      // Forward through every function and bank, then wrap
      for (int k = 1; k <= 14; k++) begin
         i_front_panel_operator.press(1'b1);
         shuffle();
         repeat (2) @(posedge clk);
         f = (k / 2) % 7;
         b = k[0];
         lm = ps.linkUp | ~ps.enabled;
         rd(8'h04, {28'h0, b, f[2:0]}, 32'hf);
         note(2'd2, 32'h100 << f, 32'h7f00);
         note(2'd1, {3'b0, b, 2'b00, pexp(f, b)}, f != 0 ? '1 :
            {6'h3f, lm[49:48], b ? lm[47:24] : lm[23:0]});
      end
      ps.enabled <= '1;
      ps.linkUp <= '0;
      repeat (3) @(posedge clk);
      blink(6'd0, 8'd3);
      repeat (10) i_front_panel_operator.press(1'b1);
      ps.autoNeg[48] <= 1'b1;
      ps.flowEn[48] <= 1'b1;
      ps.linkUp[48] <= 1'b1;
      repeat (3) @(posedge clk);
      ps.linkUp[48] <= 1'b0;
      ps.flowEn[48] <= 1'b0;
      repeat (3) @(posedge clk);
      note(2'd1, 32'h01000000, 32'h01000000);
      i_front_panel_operator.press(1'b0);
      rd(8'h04, 32'hc, 32'hf);
      i_front_panel_operator.hold(1'b1, 1'b1);
      repeat (30) @(posedge clk);
      note(2'd2, 32'h7ffc, '1);
      repeat (48) @(posedge clk);
      note(2'd2, 32'h7ffe, '1);
      rd(8'h04, 32'h40, 32'h40);
      repeat (60) @(posedge clk);
      note(2'd2, 32'h7fff, '1);
      i_front_panel_operator.hold(1'b0, 1'b0);
      repeat (20) @(posedge clk);
      rd(8'h04, 32'h0c, 32'h4f);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      note(2'd1, 32'h1fffffff, '1);
      sys_rst <= 1'b0;
      repeat (LAMP + 4) @(posedge clk);
      rd(8'h04, 32'h10, 32'h3f);
      rd(8'h00, 32'h0, '1);
      conclude();
   end
endmodule : tb_front_panel_led_selector
